// file: common/line_state_consts.vh
`ifndef LINE_STATE_CONSTS_VH
`define LINE_STATE_CONSTS_VH

// Register byte offsets on the APB bus.
`define OFS_CTRL       8'h00
`define OFS_VOLT_THR   8'h04
`define OFS_CURR_THR   8'h08
`define OFS_STATUS     8'h0C
`define OFS_NOM_VOLT   8'h10
`define OFS_NOM_CURR   8'h14

// Control and status field positions.
`define CTRL_EN_BIT    0
`define ST_DEAD_BIT    0
`define ST_LIVE_BIT    1
`define ST_VOLT_LSB    2
`define ST_CURR_LSB    5
`define ST_READY_BIT   8

// Threshold settings in percent: reset value, lower and upper limit.
`define PCT_W          7
`define VOLT_THR_RST   7'h3C
`define VOLT_THR_MIN   7'h0A
`define VOLT_THR_MAX   7'h64
`define CURR_THR_RST   7'h0A
`define CURR_THR_MIN   7'h02
`define CURR_THR_MAX   7'h64

// Percent squared, so that squared magnitudes compare with squared thresholds.
`define PCT_SQ         64'h0000_0000_0000_2710

// Reset ratio 0.95 squared, written as 361 over 400.
`define DROP_NUM       64'h0000_0000_0000_0169
`define DROP_DEN       64'h0000_0000_0000_0190

// Fourier window: samples per fundamental period and scaling.
`define WIN_IDX_W      4
`define WIN_LAST       4'hF
`define SIN_OFFSET     4'hC
`define COEF_W         16
`define AMP_SHIFT      17

// Number of channels: three voltages then three currents.
`define NUM_CH         6
`define NUM_PH         3

`endif

// file: rtl/fundamental_extractor.v
`timescale 1ns/1ps
`include "line_state_consts.vh"

module fundamental_extractor
#(
  parameter SW = 16,
  parameter MW = SW + 3
)
(
  // Clock and reset.
  input  wire                 clk,
  input  wire                 rstn,
  // Sample stream, one sample per valid pulse.
  input  wire                 sample_valid,
  input  wire signed [SW-1:0] sample,
  // Squared peak amplitude of the fundamental, in sample units.
  output reg  [2*MW-1:0]      mag_sq,
  output reg                  mag_valid
);

  localparam AW = SW + `COEF_W + `WIN_IDX_W;

  // Cosine table for sixteen points per period, scaled by 2^14.
  function signed [`COEF_W-1:0] cos_coef;
    input [`WIN_IDX_W-1:0] k;
    begin
      case (k)
        4'h0: cos_coef = 16'h4000;
        4'h1: cos_coef = 16'h3B21;
        4'h2: cos_coef = 16'h2D41;
        4'h3: cos_coef = 16'h187E;
        4'h4: cos_coef = 16'h0000;
        4'h5: cos_coef = 16'hE782;
        4'h6: cos_coef = 16'hD2BF;
        4'h7: cos_coef = 16'hC4DF;
        4'h8: cos_coef = 16'hC000;
        4'h9: cos_coef = 16'hC4DF;
        4'hA: cos_coef = 16'hD2BF;
        4'hB: cos_coef = 16'hE782;
        4'hC: cos_coef = 16'h0000;
        4'hD: cos_coef = 16'h187E;
        4'hE: cos_coef = 16'h2D41;
        default: cos_coef = 16'h3B21;
      endcase
    end
  endfunction

  reg  [`WIN_IDX_W-1:0]       idx;
  reg  signed [AW-1:0]        acc_re;
  reg  signed [AW-1:0]        acc_im;
  reg  signed [AW-1:0]        win_re;
  reg  signed [AW-1:0]        win_im;
  reg                         win_done;
  wire [`WIN_IDX_W-1:0]       sin_idx = idx + `SIN_OFFSET;
  wire signed [SW+`COEF_W-1:0] p_re = sample * cos_coef(idx);
  wire signed [SW+`COEF_W-1:0] p_im = sample * cos_coef(sin_idx);
  wire signed [AW-1:0]        sum_re = acc_re + {{`WIN_IDX_W{p_re[SW+`COEF_W-1]}}, p_re};
  wire signed [AW-1:0]        sum_im = acc_im + {{`WIN_IDX_W{p_im[SW+`COEF_W-1]}}, p_im};
  // Scaling by 2/(N*2^14) turns the bin sums into peak amplitude components.
  wire signed [MW-1:0]        amp_re = win_re[AW-1:`AMP_SHIFT];
  wire signed [MW-1:0]        amp_im = win_im[AW-1:`AMP_SHIFT];
  wire signed [2*MW-1:0]      sq_re = amp_re * amp_re;
  wire signed [2*MW-1:0]      sq_im = amp_im * amp_im;

  // Block-wise single-bin transform; a window closes every sixteen samples.
  always @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      idx      <= 4'h0;
      acc_re   <= {AW{1'b0}};
      acc_im   <= {AW{1'b0}};
      win_re   <= {AW{1'b0}};
      win_im   <= {AW{1'b0}};
      win_done <= 1'b0;
    end
    else
    begin
      win_done <= 1'b0;
      if (sample_valid)
      begin
        idx <= idx + 4'h1;
        if (idx == `WIN_LAST)
        begin
          win_re   <= sum_re;
          win_im   <= sum_im;
          acc_re   <= {AW{1'b0}};
          acc_im   <= {AW{1'b0}};
          win_done <= 1'b1;
        end
        else
        begin
          acc_re <= sum_re;
          acc_im <= sum_im;
        end
      end
    end
  end

  // Squared magnitude avoids a square root; the comparators work squared too.
  always @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      mag_sq    <= {2*MW{1'b0}};
      mag_valid <= 1'b0;
    end
    else
    begin
      mag_valid <= win_done;
      if (win_done)
        mag_sq <= sq_re + sq_im;
    end
  end

endmodule

// file: rtl/line_state_detector.v
// The implementer's own choices: register access over APB and the register offsets.
`timescale 1ns/1ps
`include "line_state_consts.vh"

module line_state_detector
#(
  parameter SW       = 16,
  parameter NOM_W    = 16,
  parameter NOM_VOLT = 16'h4000,
  parameter NOM_CURR = 16'h4000
)
(
  // Clock and reset.
  input  wire          clk,
  input  wire          rstn,
  // APB slave.
  input  wire          psel,
  input  wire          penable,
  input  wire          pwrite,
  input  wire [7:0]    paddr,
  input  wire [31:0]   pwdata,
  output reg  [31:0]   prdata,
  output wire          pready,
  output wire          pslverr,
  // Sample stream from the analog front end.
  input  wire          sample_valid,
  input  wire [SW-1:0] phase1_volt_sample,
  input  wire [SW-1:0] phase2_volt_sample,
  input  wire [SW-1:0] phase3_volt_sample,
  input  wire [SW-1:0] phase1_curr_sample,
  input  wire [SW-1:0] phase2_curr_sample,
  input  wire [SW-1:0] phase3_curr_sample,
  // Blocking input from user logic.
  input  wire          function_block_input,
  // Start flags.
  output wire          phase1_volt_over,
  output wire          phase2_volt_over,
  output wire          phase3_volt_over,
  output wire          phase1_curr_over,
  output wire          phase2_curr_over,
  output wire          phase3_curr_over,
  // Line state.
  output reg           deenergized_flag,
  output reg           energized_flag
);

  localparam MW = SW + 3;
  localparam QW = 2 * MW;
  localparam CW = 64;

  // Clamp a written percentage into its legal range.
  function [`PCT_W-1:0] clamp_pct;
    input [31:0]        value;
    input [`PCT_W-1:0]  lo;
    input [`PCT_W-1:0]  hi;
    begin
      if (value < {25'h0000000, lo})
        clamp_pct = lo;
      else if (value > {25'h0000000, hi})
        clamp_pct = hi;
      else
        clamp_pct = value[`PCT_W-1:0];
    end
  endfunction

  // Settings held by software.
  reg                  enable;
  reg  [`PCT_W-1:0]    volt_thr;
  reg  [`PCT_W-1:0]    curr_thr;
  reg  [NOM_W-1:0]     nom_volt;
  reg  [NOM_W-1:0]     nom_curr;

  // Per-channel state.
  reg  [`NUM_CH-1:0]   start;
  reg  [`NUM_CH-1:0]   seen;
  wire [QW-1:0]        mag_sq [0:`NUM_CH-1];
  wire [`NUM_CH-1:0]   mag_valid;
  wire [SW-1:0]        smp [0:`NUM_CH-1];

  // Threshold levels in sample units times 100 and their squares.
  reg  [CW-1:0]        volt_lvl_sq;
  reg  [CW-1:0]        curr_lvl_sq;
  wire [CW-1:0]        volt_lvl;
  wire [CW-1:0]        curr_lvl;

  // Bus decode.
  wire                 setup_ph;
  wire                 access_ph;
  wire                 wr_en;
  reg                  addr_hit;
  reg  [31:0]          next_rdata;
  wire                 active;
  wire                 meas_ready;

  assign setup_ph  = psel & ~penable;
  assign access_ph = psel & penable;
  assign wr_en     = access_ph & pwrite & addr_hit;

  // The slave never inserts wait states.
  assign pready  = 1'b1;
  assign pslverr = access_ph & ~addr_hit;

  // Address decode for all mapped words.
  always @*
  begin
    case (paddr)
      `OFS_CTRL:     addr_hit = 1'b1;
      `OFS_VOLT_THR: addr_hit = 1'b1;
      `OFS_CURR_THR: addr_hit = 1'b1;
      `OFS_STATUS:   addr_hit = 1'b1;
      `OFS_NOM_VOLT: addr_hit = 1'b1;
      `OFS_NOM_CURR: addr_hit = 1'b1;
      default:       addr_hit = 1'b0;
    endcase
  end

  // Writable settings; the enable comes up off.
  always @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      enable   <= 1'b0;
      volt_thr <= `VOLT_THR_RST;
      curr_thr <= `CURR_THR_RST;
      nom_volt <= NOM_VOLT;
      nom_curr <= NOM_CURR;
    end
    else if (wr_en)
    begin
      case (paddr)
        `OFS_CTRL:
          enable <= pwdata[`CTRL_EN_BIT];
        `OFS_VOLT_THR:
          volt_thr <= clamp_pct(pwdata, `VOLT_THR_MIN, `VOLT_THR_MAX);
        `OFS_CURR_THR:
          curr_thr <= clamp_pct(pwdata, `CURR_THR_MIN, `CURR_THR_MAX);
        `OFS_NOM_VOLT:
          nom_volt <= pwdata[NOM_W-1:0];
        `OFS_NOM_CURR:
          nom_curr <= pwdata[NOM_W-1:0];
        default:
          enable <= enable;
      endcase
    end
  end

  // Read mux; unmapped words read as zero.
  always @*
  begin
    next_rdata = 32'h00000000;
    case (paddr)
      `OFS_CTRL:
        next_rdata[`CTRL_EN_BIT] = enable;
      `OFS_VOLT_THR:
        next_rdata[`PCT_W-1:0] = volt_thr;
      `OFS_CURR_THR:
        next_rdata[`PCT_W-1:0] = curr_thr;
      `OFS_STATUS:
      begin
        next_rdata[`ST_DEAD_BIT] = deenergized_flag;
        next_rdata[`ST_LIVE_BIT] = energized_flag;
        next_rdata[`ST_VOLT_LSB+`NUM_PH-1:`ST_VOLT_LSB] = start[`NUM_PH-1:0];
        next_rdata[`ST_CURR_LSB+`NUM_PH-1:`ST_CURR_LSB] = start[`NUM_CH-1:`NUM_PH];
        next_rdata[`ST_READY_BIT] = meas_ready;
      end
      `OFS_NOM_VOLT:
        next_rdata[NOM_W-1:0] = nom_volt;
      `OFS_NOM_CURR:
        next_rdata[NOM_W-1:0] = nom_curr;
      default:
        next_rdata = 32'h00000000;
    endcase
  end

  // Read data is captured in the setup cycle so it is steady in the access cycle.
  always @(posedge clk or negedge rstn)
  begin
    if (!rstn)
      prdata <= 32'h00000000;
    else if (setup_ph & ~pwrite)
      prdata <= next_rdata;
  end

  // Channel order: three voltages, then three currents.
  assign smp[0] = phase1_volt_sample;
  assign smp[1] = phase2_volt_sample;
  assign smp[2] = phase3_volt_sample;
  assign smp[3] = phase1_curr_sample;
  assign smp[4] = phase2_curr_sample;
  assign smp[5] = phase3_curr_sample;

  assign active = enable & ~function_block_input;

  // Percent times the nominal rating gives the level in sample units times 100.
  assign volt_lvl = {{(CW-`PCT_W){1'b0}}, volt_thr} * {{(CW-NOM_W){1'b0}}, nom_volt};
  assign curr_lvl = {{(CW-`PCT_W){1'b0}}, curr_thr} * {{(CW-NOM_W){1'b0}}, nom_curr};

  // Squared levels are registered; a setting change takes effect a cycle later.
  always @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      volt_lvl_sq <= {CW{1'b0}};
      curr_lvl_sq <= {CW{1'b0}};
    end
    else
    begin
      volt_lvl_sq <= volt_lvl * volt_lvl;
      curr_lvl_sq <= curr_lvl * curr_lvl;
    end
  end

  genvar ch;
  generate
    for (ch = 0; ch < `NUM_CH; ch = ch + 1)
    begin : g_ch
      wire [CW-1:0] mag_pct;
      wire [CW-1:0] lvl_sq;
      wire          pick_up;
      wire          drop_off;

      // Separate fundamental extraction for this channel.
      fundamental_extractor
      #(
        .SW (SW),
        .MW (MW)
      )
      u_fund
      (
        .clk          (clk),
        .rstn         (rstn),
        .sample_valid (sample_valid),
        .sample       (smp[ch]),
        .mag_sq       (mag_sq[ch]),
        .mag_valid    (mag_valid[ch])
      );

      // Magnitude times 100, squared, against the squared threshold level.
      assign mag_pct  = {{(CW-QW){1'b0}}, mag_sq[ch]} * `PCT_SQ;
      assign lvl_sq   = (ch < `NUM_PH) ? volt_lvl_sq : curr_lvl_sq;
      assign pick_up  = mag_pct > lvl_sq;
      // A flag only falls below 0.95 of the level, so noise cannot chatter it.
      assign drop_off = (mag_pct * `DROP_DEN) < (lvl_sq * `DROP_NUM);

      // Start flag with hysteresis, updated once per finished window.
      always @(posedge clk or negedge rstn)
      begin
        if (!rstn)
        begin
          start[ch] <= 1'b0;
          seen[ch]  <= 1'b0;
        end
        else if (!active)
        begin
          start[ch] <= 1'b0;
          seen[ch]  <= 1'b0;
        end
        else if (mag_valid[ch])
        begin
          seen[ch] <= 1'b1;
          if (pick_up)
            start[ch] <= 1'b1;
          else if (drop_off)
            start[ch] <= 1'b0;
        end
      end
    end
  endgenerate

  // No decision until every channel has delivered one fresh window since enabling.
  assign meas_ready = &seen;

  // Start flags are flip-flop outputs and already cleared while inactive.
  assign phase1_volt_over = start[0];
  assign phase2_volt_over = start[1];
  assign phase3_volt_over = start[2];
  assign phase1_curr_over = start[3];
  assign phase2_curr_over = start[4];
  assign phase3_curr_over = start[5];

  // Status levels only; no event or interrupt output.
  always @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      deenergized_flag <= 1'b0;
      energized_flag   <= 1'b0;
    end
    else
    begin
      deenergized_flag <= active & meas_ready & ~(|start);
      energized_flag   <= active & meas_ready & (&start[`NUM_PH-1:0]);
    end
  end

endmodule

// file: sim/line_state_props.sv
`timescale 1ns/1ps
module line_state_props
(
  // Clock and reset.
  input wire        clk,
  input wire        rstn,
  // Bus side.
  input wire        psel,
  input wire        penable,
  input wire        pwrite,
  input wire [7:0]  paddr,
  input wire [31:0] prdata,
  input wire        pready,
  input wire        pslverr,
  // Samples, block input and flags.
  input wire        sample_valid,
  input wire        function_block_input,
  input wire        phase1_volt_over,
  input wire        phase2_volt_over,
  input wire        phase3_volt_over,
  input wire        phase1_curr_over,
  input wire        phase2_curr_over,
  input wire        phase3_curr_over,
  input wire        deenergized_flag,
  input wire        energized_flag
);
  // Address decode and the flags packed in status register order.
  wire       mapped = (paddr[1:0] == 2'h0) && (paddr <= 8'h14);
  wire [7:0] flags = {phase3_curr_over, phase2_curr_over, phase1_curr_over, phase3_volt_over,
                      phase2_volt_over, phase1_volt_over, energized_flag, deenergized_flag};
  wire       all_volt = &flags[4:2];

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rstn);

  // The slave never stalls, so a master waiting on ready cannot hang.
  a_ready_const: assert property (pready)
    else $error("pready went low.");
  a_err_unmapped: assert property (psel && penable && !mapped |-> pslverr)
    else $error("no error on unmapped access.");
  a_err_mapped: assert property (pslverr |-> psel && penable && !mapped)
    else $error("error on a mapped access.");
  a_read_zero: assert property (psel && penable && !pwrite && !mapped |-> prdata == 32'h0)
    else $error("unmapped read not zero.");
  a_status_view: assert property (psel && !penable && !pwrite && paddr == 8'h0C
    |=> prdata[7:0] == $past(flags))
    else $error("status read differs from flags.");
  a_state_excl: assert property (!(deenergized_flag && energized_flag))
    else $error("dead and live both set.");
  a_live_cause: assert property (energized_flag |-> $past(all_volt))
    else $error("live without three voltage starts.");
  a_dead_cause: assert property (deenergized_flag |-> $past(flags[7:2]) == 6'h00)
    else $error("dead while a start flag was set.");
  a_live_follow: assert property (all_volt && !function_block_input
    |=> energized_flag || !all_volt)
    else $error("live did not follow voltage starts.");
  a_block_clear: assert property (function_block_input |=> flags == 8'h00)
    else $error("flags stayed up while blocked.");
  a_start_window: assert property ($rose(phase1_volt_over) |-> $past(sample_valid, 3))
    else $error("start flag rose outside a window result.");
endmodule

bind line_state_detector line_state_props u_props
(
  .clk(clk), .rstn(rstn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
  .prdata(prdata), .pready(pready), .pslverr(pslverr), .sample_valid(sample_valid),
  .function_block_input(function_block_input), .phase1_volt_over(phase1_volt_over),
  .phase2_volt_over(phase2_volt_over), .phase3_volt_over(phase3_volt_over),
  .phase1_curr_over(phase1_curr_over), .phase2_curr_over(phase2_curr_over),
  .phase3_curr_over(phase3_curr_over), .deenergized_flag(deenergized_flag),
  .energized_flag(energized_flag)
);

// file: sim/front_end_model.sv
`timescale 1ns/1ps
module front_end_model
(
  // Clock and reset.
  input  wire        clk,
  input  wire        rstn,
  // Peak amplitudes, voltages L1 to L3 then currents, and pacing.
  input  wire [95:0] amp,
  input  wire        slow,
  // Sample stream.
  output reg         sample_valid,
  output reg  [95:0] samples
);
  reg [3:0] idx;
  reg [1:0] gap;
  integer   k;

  // Between pulses the data turns over, so reading stale samples shows up.
  // Six channels together.
  always @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      idx <= 4'h0;
      gap <= 2'h0;
      sample_valid <= 1'b0;
      samples <= 96'h0;
    end
    else if (slow && gap != 2'h2)
    begin
      gap <= gap + 2'h1;
      sample_valid <= 1'b0;
      samples <= ~samples;
    end
    else
    begin
      gap <= 2'h0;
      idx <= idx + 4'h1;
      sample_valid <= 1'b1;
      for (k = 0; k < 6; k = k + 1)
        samples[16*k +: 16] <= 16'($rtoi(amp[16*k +: 16] * $sin(6.2831853 * idx / 16.0)));
    end
  end
endmodule

// file: sim/line_state_detector_tb_top.sv
`timescale 1ns/1ps
module line_state_detector_tb_top;
  // Stimulus, all given a value at time zero.
  reg         clk = 1'b0, rstn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  reg         blk = 1'b0, slow = 1'b0, err;
  reg  [7:0]  paddr = 8'h00;
  reg  [31:0] pwdata = 32'h0, rd;
  reg  [95:0] amp = 96'h0;
  wire [31:0] prdata;
  wire        pready, pslverr, sv;
  wire [95:0] smp;
  wire [7:0]  fl;
  integer     error_cnt = 0, total_checks = 0, cycles = 0, n, i;
  localparam [15:0] HI = 16'h3A98;
  // Threshold writes and what the limits should leave behind.
  reg  [7:0]  t_adr [7] = '{8'h04, 8'h04, 8'h04, 8'h08, 8'h08, 8'h08, 8'h04};
  reg  [31:0] t_val [7] = '{32'h9, 32'hA, 32'h100, 32'h1, 32'h64, 32'hA, 32'h3C};
  reg  [31:0] t_exp [7] = '{32'hA, 32'hA, 32'h64, 32'h2, 32'h64, 32'hA, 32'h3C};

  front_end_model fe (.clk(clk), .rstn(rstn), .amp(amp), .slow(slow), .sample_valid(sv),
    .samples(smp));
  line_state_detector dut (.clk(clk), .rstn(rstn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .sample_valid(sv), .phase1_volt_sample(smp[15:0]),
    .phase2_volt_sample(smp[31:16]), .phase3_volt_sample(smp[47:32]),
    .phase1_curr_sample(smp[63:48]), .phase2_curr_sample(smp[79:64]),
    .phase3_curr_sample(smp[95:80]), .function_block_input(blk),
    .deenergized_flag(fl[0]), .energized_flag(fl[1]), .phase1_volt_over(fl[2]),
    .phase2_volt_over(fl[3]), .phase3_volt_over(fl[4]), .phase1_curr_over(fl[5]),
    .phase2_curr_over(fl[6]), .phase3_curr_over(fl[7]));

  // Clock and a hang limit well above the expected run length.
  always #5 clk = ~clk;
  always @(posedge clk)
  begin
    cycles = cycles + 1;
    if (cycles == 6000)
    begin
      error_cnt = error_cnt + 1;
      give_verdict;
    end
  end

  // One transfer; the request holds until ready is seen at an edge.
  task apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
  begin
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1)
      @(posedge clk);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  end
  endtask

  task check(input logic [31:0] got, input logic [31:0] exp, input string what);
  begin
    total_checks = total_checks + 1;
    if (got !== exp)
    begin
      error_cnt = error_cnt + 1;
      $display("CHECK FAILED at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  end
  endtask

  // Two and a half windows, counted in sample pulses, plus four cycles for the pipeline.
  task settle;
  begin
    n = 0;
    while (n < 40)
    begin
      @(posedge clk);
      if (sv === 1'b1)
        n = n + 1;
    end
    repeat (4) @(posedge clk);
  end
  endtask

  // Apply amplitudes, then judge the flag pins and the status register.
  task run_case(input logic [95:0] a, input logic [7:0] e, input string name);
  begin
    amp <= a;
    settle;
    check({24'h0, fl}, {24'h0, e}, name);
    apb(1'b0, 8'h0C, 32'h0);
    check({24'h0, rd[7:0]}, {24'h0, e}, name);
  end
  endtask

  task t_reset;
  begin
    apb(1'b0, 8'h00, 32'h0);
    check(rd, 32'h0, "enable");
    apb(1'b0, 8'h04, 32'h0);
    check(rd, 32'h3C, "volt thr");
    apb(1'b0, 8'h08, 32'h0);
    check(rd, 32'hA, "curr thr");
    check({24'h0, fl}, 32'h0, "idle flags");
    apb(1'b0, 8'h0C, 32'h0);
    check(rd, 32'h0, "idle status");
    apb(1'b0, 8'h10, 32'h0);
    check(rd, 32'h4000, "nominal volt");
    apb(1'b0, 8'h14, 32'h0);
    check(rd, 32'h4000, "nominal curr");
    $display("reset test done");
  end
  endtask

  task t_limits;
  begin
    for (i = 0; i < 7; i = i + 1)
    begin
      apb(1'b1, t_adr[i], t_val[i]);
      apb(1'b0, t_adr[i], 32'h0);
      check(rd, t_exp[i], "limit");
    end
    apb(1'b0, 8'h18, 32'h0);
    check({31'h0, err}, 32'h1, "unmapped err");
    check(rd, 32'h0, "unmapped data");
    $display("limit test done");
  end
  endtask

  task t_states;
  begin
    apb(1'b1, 8'h00, 32'h1);
    run_case({48'h0, HI, HI, HI}, 8'h1E, "live");
    check({31'h0, rd[8]}, 32'h1, "ready");
    run_case(96'h0, 8'h01, "dead");
    run_case({HI, HI, HI, HI, HI, HI}, 8'hFE, "loaded");
    $display("state test done");
  end
  endtask

  // Each channel alone above threshold, at a slow sample pace.
  task t_single;
  begin
    slow <= 1'b1;
    for (i = 0; i < 6; i = i + 1)
      run_case({80'h0, HI} << (16 * i), 8'h04 << i, "single");
    slow <= 1'b0;
    $display("single channel test done");
  end
  endtask

  task t_block;
  begin
    blk <= 1'b1;
    run_case({48'h0, HI, HI, HI}, 8'h00, "blocked");
    check({31'h0, rd[8]}, 32'h0, "not ready");
    blk <= 1'b0;
    run_case({48'h0, HI, HI, HI}, 8'h1E, "unblocked");
    apb(1'b1, 8'h00, 32'h0);
    settle;
    check({24'h0, fl}, 32'h0, "disabled");
    $display("block test done");
  end
  endtask

  task give_verdict;
  begin
    $display("Checks %0d, mismatches %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  end
  endtask

  initial
  begin
    repeat (2) @(posedge clk);
    rstn <= 1'b1;
    @(posedge clk);
    t_reset;
    t_limits;
    t_states;
    t_single;
    t_block;
    give_verdict;
  end
endmodule
